// ---- rtl/agu_pkg.sv ----
// Package with types and constants for the address generation unit.
package agu_pkg;

  localparam int ADDR_W = 32;
  localparam int PORT_W = 16;
  localparam int GPR_N = 8;

  // General register numbers; stack pointer and frame pointer matter to segment choice.
  localparam logic [2:0] GPR_STACK_POINTER = 3'h4;
  localparam logic [2:0] GPR_FRAME_POINTER = 3'h5;
  localparam logic [2:0] GPR_DEST_INDEX = 3'h7;

  // Base plus index costs data references one extra clock; all other modes and reference kinds none.
  localparam int BASE_INDEX_EXTRA_CLKS = 1;

  // Reset values of the hold counter and the check registers.
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [1:0] RST_CNT = 2'h0;

  typedef enum logic [2:0] {
    AGU_SEG_EXTRA,
    AGU_SEG_CODE,
    AGU_SEG_STACK,
    AGU_SEG_DATA,
    AGU_SEG_EXTRA_F,
    AGU_SEG_EXTRA_G
  } agu_seg_t;

  // Kind of reference being made.
  typedef enum logic [2:0] {
    AGU_REF_CODE_FETCH,
    AGU_REF_STACK_PUSH,
    AGU_REF_STACK_POP,
    AGU_REF_STRING_DEST,
    AGU_REF_DATA,
    AGU_REF_IO
  } agu_ref_t;

  // Operand modes: register, immediate, and nine memory modes.
  typedef enum logic [3:0] {
    AGU_MODE_REGISTER,
    AGU_MODE_IMMEDIATE,
    AGU_MODE_DIRECT,
    AGU_MODE_REG_INDIRECT,
    AGU_MODE_BASED,
    AGU_MODE_INDEX,
    AGU_MODE_SCALED_INDEX,
    AGU_MODE_BASED_INDEX,
    AGU_MODE_BASED_SCALED_INDEX,
    AGU_MODE_BASED_INDEX_DISP,
    AGU_MODE_BASED_SCALED_INDEX_DISP
  } agu_mode_t;

  typedef enum logic [1:0] {
    AGU_IO_IMM8,
    AGU_IO_PORT_REG
  } agu_io_src_t;

  // One request from the decoder.
  typedef struct packed {
    agu_ref_t    ref_kind;
    agu_mode_t   mode;
    logic        override_valid;
    agu_seg_t    override_seg;
    logic [2:0]  base_sel;
    logic [2:0]  index_sel;
    logic [1:0]  scale_log2;
    logic        disp_is_8;
    logic [31:0] disp;
    logic [31:0] immediate;
    logic [2:0]  reg_sel;
    logic [1:0]  reg_width;
    agu_io_src_t io_src;
    logic [7:0]  io_imm8;
  } agu_req_t;

  // One answer to the segmentation and bus logic.
  typedef struct packed {
    agu_seg_t    seg;
    logic [31:0] effective_addr;
    logic [31:0] linear_addr;
    logic [31:0] operand;
    logic        operand_valid;
    logic        mem_not_io;
  } agu_resp_t;

endpackage

// ---- rtl/agu_seg_select.sv ----
// Segment register selection for one memory reference.
`timescale 1ns/100ps
module agu_seg_select (
  input  wire agu_pkg::agu_ref_t ref_kind_in,
  input  wire logic              override_valid_in,
  input  wire agu_pkg::agu_seg_t override_seg_in,
  input  wire logic [2:0]        base_sel_in,
  input  wire logic              base_used_in,
  output agu_pkg::agu_seg_t      seg_out
);

  always_comb begin
    seg_out = agu_pkg::AGU_SEG_DATA;
    unique case (ref_kind_in)
      agu_pkg::AGU_REF_CODE_FETCH: begin
        seg_out = agu_pkg::AGU_SEG_CODE;
      end
      agu_pkg::AGU_REF_STACK_PUSH: begin
        seg_out = agu_pkg::AGU_SEG_STACK;
      end
      agu_pkg::AGU_REF_STACK_POP: begin
        seg_out = agu_pkg::AGU_SEG_STACK;
      end
      agu_pkg::AGU_REF_STRING_DEST: begin
        seg_out = agu_pkg::AGU_SEG_EXTRA;
      end
      agu_pkg::AGU_REF_IO: begin
        seg_out = agu_pkg::AGU_SEG_DATA;
      end
      agu_pkg::AGU_REF_DATA: begin
        if (override_valid_in) begin
          seg_out = override_seg_in;
        end else if (base_used_in && (base_sel_in == agu_pkg::GPR_STACK_POINTER ||
                                      base_sel_in == agu_pkg::GPR_FRAME_POINTER)) begin
          seg_out = agu_pkg::AGU_SEG_STACK;
        end else begin
          seg_out = agu_pkg::AGU_SEG_DATA;
        end
      end
      default: begin
        seg_out = agu_pkg::AGU_SEG_DATA;
      end
    endcase
  end

endmodule

// ---- rtl/agu_top.sv ----
// Address generation unit: segment choice, effective, linear and port addresses.
`timescale 1ns/100ps
// What this block does
// - Instruction fetches always use the code segment; overrides ignored.
// - Push, call, interrupt stack writes use the stack segment, never overridden.
// - Pop, return, interrupt-return stack reads use the stack segment, never overridden.
// - String store and move destinations use extra segment with destination index base.
// - Other data references default to data segment, or stack segment when based on stack or frame pointer; any override may replace it.
// - An override prefix replaces the implied segment of data references; only way to reach extra segments F and G.
// - Segments from one byte to four gigabytes are supported without limit checks.
// - Segment bases may overlap freely, including all at zero.
// - Port space is 64 kilobytes, used as 8, 16 or 32 bit ports.
// - Port addresses bypass segment and page translation.
// - Port address comes from an 8-bit immediate or the port address register.
// - Narrow port addresses are zero extended on upper address lines.
// - Memory-versus-port select is driven low during port operations.
// - Eleven operand modes: register, immediate and nine memory modes.
// - Register mode takes a general register; immediate mode takes the encoding.
// - Linear address is segment base plus effective address.
// - Effective address is base plus scaled index plus displacement, parts optional.
// - Displacement is 8 or 32 bits; the 8-bit form is sign extended.
// - Any register may be base; any except stack pointer may be index.
// - Index is scaled by 1, 2, 4 or 8 through a left shift.
// - Address is free except base plus index on data references, which takes one extra clock.
module agu_top #(
  parameter int ADDR_W = agu_pkg::ADDR_W,
  parameter int GPR_N  = agu_pkg::GPR_N
) (
  input  wire logic                  clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  req_valid_in,
  input  wire agu_pkg::agu_req_t     req_in,
  input  wire logic [GPR_N*32-1:0]   gpr_file_in,
  input  wire logic [15:0]           port_address_reg_in,
  input  wire logic [31:0]           code_seg_base_in,
  input  wire logic [31:0]           stack_seg_base_in,
  input  wire logic [31:0]           data_seg_reg_base_in,
  input  wire logic [31:0]           extra_seg_reg_base_in,
  input  wire logic [31:0]           extra_seg_reg_f_base_in,
  input  wire logic [31:0]           extra_seg_reg_g_base_in,
  output logic                       req_ready_out,
  output logic                       resp_valid_out,
  output agu_pkg::agu_resp_t         resp_out,
  output logic                       index_fault_out
);

  if (ADDR_W != 32 || GPR_N != 8) begin : g_bad_params
    $error("agu_top supports only a 32-bit address and eight general registers.");
  end

  // Combinational decode of the incoming request.
  logic [31:0]       base_val;
  logic [31:0]       index_val;
  logic [31:0]       scaled_index;
  logic [31:0]       disp_val;
  logic [31:0]       next_ea;
  logic [31:0]       seg_base;
  logic [31:0]       next_linear;
  logic [31:0]       reg_operand;
  logic [31:0]       io_addr;
  logic              use_base;
  logic              use_index;
  logic              use_disp;
  logic              use_scale;
  logic              two_cycle;
  logic              bad_index;
  agu_pkg::agu_seg_t seg_sel;
  logic [2:0]        base_pick;

  // Holding stage for the extra clock of base plus index modes.
  logic              hold_busy;
  logic [1:0]        hold_cnt;
  logic              hold_fault;
  agu_pkg::agu_resp_t hold_resp;

  always_comb begin
    use_base  = 1'b0;
    use_index = 1'b0;
    use_disp  = 1'b0;
    use_scale = 1'b0;
    unique case (req_in.mode)
      agu_pkg::AGU_MODE_REGISTER, agu_pkg::AGU_MODE_IMMEDIATE: begin
        use_disp = 1'b0;
      end
      agu_pkg::AGU_MODE_DIRECT: begin
        use_disp = 1'b1;
      end
      agu_pkg::AGU_MODE_REG_INDIRECT: begin
        use_base = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED: begin
        use_base = 1'b1;
        use_disp = 1'b1;
      end
      agu_pkg::AGU_MODE_INDEX: begin
        use_index = 1'b1;
        use_disp  = 1'b1;
      end
      agu_pkg::AGU_MODE_SCALED_INDEX: begin
        use_index = 1'b1;
        use_disp  = 1'b1;
        use_scale = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_INDEX: begin
        use_base  = 1'b1;
        use_index = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_SCALED_INDEX: begin
        use_base  = 1'b1;
        use_index = 1'b1;
        use_scale = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_INDEX_DISP: begin
        use_base  = 1'b1;
        use_index = 1'b1;
        use_disp  = 1'b1;
      end
      agu_pkg::AGU_MODE_BASED_SCALED_INDEX_DISP: begin
        use_base  = 1'b1;
        use_index = 1'b1;
        use_disp  = 1'b1;
        use_scale = 1'b1;
      end
      default: begin
        use_disp = 1'b0;
      end
    endcase
  end

  // String destinations are forced onto the destination index as base.
  assign base_pick = (req_in.ref_kind == agu_pkg::AGU_REF_STRING_DEST) ?
                     agu_pkg::GPR_DEST_INDEX : req_in.base_sel;

  // Any register may serve as base; the stack pointer is refused as index.
  assign base_val  = use_base ? gpr_file_in[base_pick*32 +: 32] : 32'h0000_0000;
  assign bad_index = use_index && (req_in.index_sel == agu_pkg::GPR_STACK_POINTER);
  assign index_val = (use_index && !bad_index) ?
                     gpr_file_in[req_in.index_sel*32 +: 32] : 32'h0000_0000;

  // Scale by a shift of zero to three bits, only in the scaled modes.
  assign scaled_index = use_scale ? (index_val << req_in.scale_log2) : index_val;

  // Sign extension of the short displacement.
  assign disp_val = !use_disp ? 32'h0000_0000 :
                    req_in.disp_is_8 ? {{24{req_in.disp[7]}}, req_in.disp[7:0]} :
                    req_in.disp;

  // Sums wrap at 32 bits; carries are dropped.
  assign next_ea = 32'(base_val + scaled_index + disp_val);

  agu_seg_select u_seg_select (
    .ref_kind_in       (req_in.ref_kind),
    .override_valid_in (req_in.override_valid),
    .override_seg_in   (req_in.override_seg),
    .base_sel_in       (base_pick),
    .base_used_in      (use_base),
    .seg_out           (seg_sel)
  );

  // Base of the chosen segment.
  always_comb begin
    seg_base = data_seg_reg_base_in;
    unique case (seg_sel)
      agu_pkg::AGU_SEG_CODE:    seg_base = code_seg_base_in;
      agu_pkg::AGU_SEG_STACK:   seg_base = stack_seg_base_in;
      agu_pkg::AGU_SEG_DATA:    seg_base = data_seg_reg_base_in;
      agu_pkg::AGU_SEG_EXTRA:   seg_base = extra_seg_reg_base_in;
      agu_pkg::AGU_SEG_EXTRA_F: seg_base = extra_seg_reg_f_base_in;
      agu_pkg::AGU_SEG_EXTRA_G: seg_base = extra_seg_reg_g_base_in;
      default:                  seg_base = data_seg_reg_base_in;
    endcase
  end

  // No limit or overlap check: every base and every offset is accepted.
  assign next_linear = 32'(seg_base + next_ea);

  // Port address, zero extended, never translated.
  assign io_addr = (req_in.io_src == agu_pkg::AGU_IO_IMM8) ?
                   {24'h00_0000, req_in.io_imm8} :
                   {16'h0000, port_address_reg_in};

  // Register operand by width: byte, word or dword.
  always_comb begin
    reg_operand = gpr_file_in[req_in.reg_sel*32 +: 32];
    unique case (req_in.reg_width)
      2'h0:    reg_operand = {24'h00_0000, reg_operand[7:0]};
      2'h1:    reg_operand = {16'h0000, reg_operand[15:0]};
      default: reg_operand = reg_operand;
    endcase
  end

  // Only data references pay the extra clock of base plus index.
  assign two_cycle = use_base && use_index && (req_in.ref_kind == agu_pkg::AGU_REF_DATA);

  // Answer assembled from the request standing at the inputs.
  function automatic agu_pkg::agu_resp_t build_resp();
    agu_pkg::agu_resp_t r;
    r = '0;
    r.seg           = seg_sel;
    r.mem_not_io    = 1'b1;
    r.effective_addr = next_ea;
    r.linear_addr   = next_linear;
    if (req_in.ref_kind == agu_pkg::AGU_REF_IO) begin
      r.effective_addr = io_addr;
      r.linear_addr    = io_addr;
      r.mem_not_io     = 1'b0;
    end else if (req_in.mode == agu_pkg::AGU_MODE_REGISTER) begin
      r.operand       = reg_operand;
      r.operand_valid = 1'b1;
    end else if (req_in.mode == agu_pkg::AGU_MODE_IMMEDIATE) begin
      r.operand       = req_in.immediate;
      r.operand_valid = 1'b1;
    end
    return r;
  endfunction

  // Ready drops while a base plus index request spends its extra clock.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold_busy <= 1'b0;
      hold_cnt  <= agu_pkg::RST_CNT;
      hold_resp <= '0;
      hold_fault <= 1'b0;
    end else if (hold_busy) begin
      if (hold_cnt == 2'(agu_pkg::BASE_INDEX_EXTRA_CLKS)) begin
        hold_busy <= 1'b0;
        hold_cnt  <= agu_pkg::RST_CNT;
      end else begin
        hold_cnt <= 2'(hold_cnt + 2'h1);
      end
    end else if (req_valid_in && two_cycle) begin
      hold_busy <= 1'b1;
      hold_cnt  <= 2'h1;
      hold_resp <= build_resp();
      hold_fault <= bad_index;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      req_ready_out <= 1'b1;
    end else begin
      req_ready_out <= !(req_valid_in && req_ready_out && two_cycle) && !(hold_busy &&
                       hold_cnt != 2'(agu_pkg::BASE_INDEX_EXTRA_CLKS));
    end
  end

  // The fault pulse rides with its own answer, held ones included.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      resp_valid_out  <= 1'b0;
      resp_out        <= '0;
      index_fault_out <= 1'b0;
    end else if (hold_busy && hold_cnt == 2'(agu_pkg::BASE_INDEX_EXTRA_CLKS)) begin
      resp_valid_out  <= 1'b1;
      resp_out        <= hold_resp;
      index_fault_out <= hold_fault;
    end else if (req_valid_in && req_ready_out && !two_cycle) begin
      resp_valid_out  <= 1'b1;
      resp_out        <= build_resp();
      index_fault_out <= bad_index;
    end else begin
      resp_valid_out  <= 1'b0;
      index_fault_out <= 1'b0;
    end
  end

  // Checks.
  logic        past_valid;
  logic        was_io;
  logic [31:0] past_io_addr;
  logic        was_bad;
  logic [31:0] past_seg_base;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      past_valid   <= 1'b0;
      was_io       <= 1'b0;
      past_io_addr <= agu_pkg::RST_ADDR;
      was_bad      <= 1'b0;
      past_seg_base <= agu_pkg::RST_ADDR;
    end else begin
      past_valid   <= req_valid_in && req_ready_out && !two_cycle;
      was_io       <= req_in.ref_kind == agu_pkg::AGU_REF_IO;
      past_io_addr <= io_addr;
      was_bad      <= bad_index;
      past_seg_base <= seg_base;
    end
  end

  a_code_fetch_seg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_in.ref_kind == agu_pkg::AGU_REF_CODE_FETCH |-> seg_sel == agu_pkg::AGU_SEG_CODE)
    else $error("Code fetch did not use the code segment.");
  a_push_seg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_in.ref_kind == agu_pkg::AGU_REF_STACK_PUSH |-> seg_sel == agu_pkg::AGU_SEG_STACK)
    else $error("Stack write did not use the stack segment.");
  a_pop_seg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_in.ref_kind == agu_pkg::AGU_REF_STACK_POP |-> seg_sel == agu_pkg::AGU_SEG_STACK)
    else $error("Stack read did not use the stack segment.");
  a_string_dest_seg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_in.ref_kind == agu_pkg::AGU_REF_STRING_DEST |-> seg_sel == agu_pkg::AGU_SEG_EXTRA)
    else $error("String destination did not use the extra segment.");
  a_data_override: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_in.ref_kind == agu_pkg::AGU_REF_DATA && req_in.override_valid
      |-> seg_sel == req_in.override_seg)
    else $error("Override prefix was not applied.");
  a_io_mem_sel: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid && was_io |-> !resp_out.mem_not_io && resp_valid_out)
    else $error("Port access did not drive the memory select low.");
  a_io_zero_ext: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid && was_io |-> resp_out.linear_addr == past_io_addr &&
      resp_out.linear_addr[31:16] == 16'h0000)
    else $error("Port address not zero extended.");
  a_linear_sum: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid && !was_io
      |-> resp_out.linear_addr == 32'(past_seg_base + resp_out.effective_addr))
    else $error("Linear address is not base plus offset.");
  a_extra_clock: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_valid_in && req_ready_out && two_cycle |=> !resp_valid_out ##1 resp_valid_out)
    else $error("Base plus index did not take exactly one extra clock.");
  a_no_stack_index: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid && was_bad |-> index_fault_out)
    else $error("Stack pointer as index was not flagged.");
  a_fault_pulse: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    index_fault_out |-> resp_valid_out)
    else $error("Index fault appeared without an answer.");
  a_single_latency: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid |-> resp_valid_out)
    else $error("Single clock request was not answered on the next clock.");
  a_refuse_busy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_valid_in && req_ready_out && two_cycle |=> !req_ready_out ##1 req_ready_out)
    else $error("Ready did not drop for exactly the extra clock.");
  a_io_untranslated: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    past_valid && was_io |-> resp_out.effective_addr == resp_out.linear_addr)
    else $error("Port address passed through translation.");

  c_io_access: cover property (@(posedge clk_in) past_valid && was_io);
  c_two_cycle: cover property (@(posedge clk_in) req_valid_in && req_ready_out && two_cycle);
  c_override: cover property (@(posedge clk_in) req_valid_in && req_in.override_valid);
  c_wrap: cover property (@(posedge clk_in) req_valid_in && next_linear < seg_base);
  c_index_fault: cover property (@(posedge clk_in) index_fault_out);

endmodule

// ---- verif/agu_core_model.sv ----
// Model of the register file and segment bases that face the address unit.
`timescale 1ns/100ps
module agu_core_model (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         load_in,
  input  wire logic [255:0] gpr_load_in,
  input  wire logic [191:0] base_load_in,
  output logic      [255:0] gpr_file_out,
  output logic      [191:0] bases_out
);
  // Bases are taken as given, so segments may overlap or all sit at zero.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      gpr_file_out <= 256'h0;
      bases_out    <= 192'h0;
    end else if (load_in) begin
      gpr_file_out <= gpr_load_in;
      bases_out    <= base_load_in;
    end
  end
endmodule

// ---- verif/agu_top_tb.sv ----
// Self-checking bench for the address generation unit.
`timescale 1ns/100ps
module agu_top_tb;
  typedef struct {
    agu_pkg::agu_resp_t r;
    logic               fault;
    int                 kind;
    int                 cyc;
  } agu_note_t;
  logic               clk_in              = 1'b0;
  logic               sys_rst_in          = 1'b1;
  logic               req_valid_in        = 1'b0;
  agu_pkg::agu_req_t  req_in              = '0;
  logic [15:0]        port_address_reg_in = 16'h0;
  logic               load_in             = 1'b0;
  logic [255:0]       gpr_load            = 256'h0;
  logic [191:0]       base_load           = 192'h0;
  logic [255:0]       gpr_file;
  logic [191:0]       bases;
  logic               req_ready_out;
  logic               resp_valid_out;
  logic               index_fault_out;
  agu_pkg::agu_resp_t resp_out;
  agu_note_t          notes[$];
  int                 errors          = 0;
  int                 samples_checked = 0;
  int                 cyc             = 0;
  int                 busy_cyc        = -1;

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;

  agu_core_model peer (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .load_in(load_in),
    .gpr_load_in(gpr_load), .base_load_in(base_load), .gpr_file_out(gpr_file),
    .bases_out(bases));
  agu_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .gpr_file_in(gpr_file), .port_address_reg_in(port_address_reg_in),
    .code_seg_base_in(bases[63:32]), .stack_seg_base_in(bases[95:64]),
    .data_seg_reg_base_in(bases[127:96]), .extra_seg_reg_base_in(bases[31:0]),
    .extra_seg_reg_f_base_in(bases[159:128]), .extra_seg_reg_g_base_in(bases[191:160]),
    .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out), .resp_out(resp_out),
    .index_fault_out(index_fault_out));

  task automatic compare_word(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic compare_seg(input agu_pkg::agu_seg_t e, input agu_pkg::agu_seg_t g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error seg expected %0d seen %0d", e, g);
    end
  endtask

  task automatic compare_bit(input string name, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic agu_note_t predict(input agu_pkg::agu_req_t q, input logic [15:0] p);
    agu_note_t         n;
    logic [31:0]       b;
    logic [31:0]       x;
    logic [31:0]       d;
    logic [31:0]       v;
    logic [2:0]        bs;
    logic              ub;
    logic              ux;
    int                m;
    int                si;
    agu_pkg::agu_seg_t s;
    m = q.mode;
    n.r = '0;
    n.kind = 0;
    ub = m inside {3, 4, 7, 8, 9, 10};
    ux = m inside {5, 6, 7, 8, 9, 10};
    bs = (q.ref_kind == agu_pkg::AGU_REF_STRING_DEST) ? agu_pkg::GPR_DEST_INDEX : q.base_sel;
    b = ub ? gpr_load[bs*32+:32] : 32'h0;
    n.fault = ux && q.index_sel == agu_pkg::GPR_STACK_POINTER;
    x = (ux && !n.fault) ? gpr_load[q.index_sel*32+:32] : 32'h0;
    if (m inside {6, 8, 10}) x = x << q.scale_log2;
    d = q.disp_is_8 ? {{24{q.disp[7]}}, q.disp[7:0]} : q.disp;
    if (!(m inside {2, 4, 5, 6, 9, 10})) d = 32'h0;
    case (q.ref_kind)
      agu_pkg::AGU_REF_CODE_FETCH: s = agu_pkg::AGU_SEG_CODE;
      agu_pkg::AGU_REF_STACK_PUSH, agu_pkg::AGU_REF_STACK_POP: s = agu_pkg::AGU_SEG_STACK;
      agu_pkg::AGU_REF_STRING_DEST: s = agu_pkg::AGU_SEG_EXTRA;
      agu_pkg::AGU_REF_IO: s = agu_pkg::AGU_SEG_DATA;
      default: s = q.override_valid ? q.override_seg : (ub && bs inside {3'h4, 3'h5}) ?
        agu_pkg::AGU_SEG_STACK : agu_pkg::AGU_SEG_DATA;
    endcase
    si = s;
    n.r.seg = s;
    n.r.effective_addr = b + x + d;
    n.r.linear_addr = n.r.effective_addr + base_load[si*32+:32];
    n.r.mem_not_io = 1'b1;
    n.cyc = (q.ref_kind == agu_pkg::AGU_REF_DATA && ub && ux) ? 3 : 2;
    v = gpr_load[q.reg_sel*32+:32];
    if (m < 2) begin
      n.kind = 1;
      n.r.operand = (m == 1) ? q.immediate : (q.reg_width == 2'h0) ? {24'h0, v[7:0]} :
        (q.reg_width == 2'h1) ? {16'h0, v[15:0]} : v;
    end
    if (q.ref_kind == agu_pkg::AGU_REF_IO) begin
      n.kind = 2;
      n.r.linear_addr = (q.io_src == agu_pkg::AGU_IO_IMM8) ? {24'h0, q.io_imm8} : {16'h0, p};
      n.r.mem_not_io = 1'b0;
    end
    return n;
  endfunction

  task automatic send(input agu_pkg::agu_req_t q, input logic [15:0] p);
    agu_note_t n;
    int        t;
    req_valid_in <= 1'b1;
    req_in <= q;
    port_address_reg_in <= p;
    @(negedge clk_in);
    for (t = 0; t < 8 && req_ready_out !== 1'b1; t++) @(negedge clk_in);
    @(posedge clk_in);
    n = predict(q, p);
    n.cyc += cyc - 1;
    if (n.cyc - cyc == 2) busy_cyc = cyc + 1;
    notes.push_back(n);
  endtask

  task automatic check_reset;
    @(negedge clk_in);
    compare_bit("req_ready_out", 1'b1, req_ready_out);
    compare_bit("resp_valid_out", 1'b0, resp_valid_out);
    compare_bit("index_fault_out", 1'b0, index_fault_out);
    compare_word("linear_addr", 32'h0, resp_out.linear_addr);
  endtask

  always @(negedge clk_in) begin
    agu_note_t n;
    if (cyc == busy_cyc) compare_bit("req_ready_out", 1'b0, req_ready_out);
    if (resp_valid_out === 1'b1) begin
      n.cyc = -1;
      if (notes.size() > 0) n = notes.pop_front();
      compare_word("answer cycle", 32'(n.cyc), 32'(cyc));
      compare_bit("index_fault_out", n.fault, index_fault_out);
      if (n.kind == 1) begin
        compare_word("operand", n.r.operand, resp_out.operand);
        compare_bit("operand_valid", 1'b1, resp_out.operand_valid);
      end else begin
        compare_word("linear_addr", n.r.linear_addr, resp_out.linear_addr);
        compare_bit("mem_not_io", n.r.mem_not_io, resp_out.mem_not_io);
        compare_seg(n.r.seg, resp_out.seg);
      end
      if (n.kind == 0) begin
        compare_word("effective", n.r.effective_addr, resp_out.effective_addr);
        compare_bit("operand_valid", 1'b0, resp_out.operand_valid);
      end
    end
  end

  initial begin
    agu_pkg::agu_req_t q;
    logic [15:0]       p;
    void'($urandom(32'hcfd1_9619));
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check_reset();
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      sys_rst_in <= (r == 2);
      for (int i = 0; i < 8; i++) gpr_load[i*32+:32] <= $urandom();
      for (int i = 0; i < 6; i++) base_load[i*32+:32] <= (r == 0) ? 32'h0 : $urandom();
      @(posedge clk_in);
      sys_rst_in <= 1'b0;
      load_in <= 1'b1;
      if (r == 2) check_reset();
      @(posedge clk_in);
      load_in <= 1'b0;
      for (int k = 0; k < 6; k++) begin
        for (int m = 0; m < 11; m++) begin
          for (int v = 0; v < 2; v++) begin
            q.ref_kind = agu_pkg::agu_ref_t'(k);
            q.mode = agu_pkg::agu_mode_t'(((k != 4 && m < 2) || k == 3 || k == 5) ? 3 : m);
            q.override_valid = v[0];
            q.override_seg = agu_pkg::agu_seg_t'($urandom_range(5, 0));
            q.base_sel = 3'($urandom_range(7, 0));
            q.index_sel = (q.mode > 4) ? 3'($urandom_range(7, 0)) : 3'h0;
            q.scale_log2 = 2'($urandom_range(3, 0));
            q.disp_is_8 = 1'($urandom_range(1, 0));
            q.disp = $urandom();
            q.immediate = $urandom();
            q.reg_width = 2'($urandom_range(2, 0));
            q.reg_sel = 3'($urandom_range(q.reg_width == 2'h0 ? 3 : 7, 0));
            q.io_src = agu_pkg::agu_io_src_t'(v);
            q.io_imm8 = 8'($urandom_range(8'hf7, 0));
            p = 16'($urandom_range(16'hffff, 0));
            if (p inside {[16'h00f8:16'h00ff]}) p = 16'h0100;
            send(q, p);
          end
        end
      end
      req_valid_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      compare_word("pending answers", 32'h0, 32'(notes.size()));
    end
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    final_report();
  end
endmodule
